// ===== rtl/rt_hw_int_map.vh
`ifndef RT_HW_INT_MAP_VH
`define RT_HW_INT_MAP_VH

// ==========================================================
// Register addresses on the serial host port
`define ADDR_HW_PENDING     7'h06
`define ADDR_HW_ENABLE      7'h0F
`define ADDR_HW_OUT_ENABLE  7'h13
`define ADDR_EXT_CONFIG     7'h4D

// ==========================================================
// Hardware interrupt bit positions
`define BIT_MON_MATCH       6
`define BIT_ADDR_PARITY     3
`define BIT_RT_SUMMARY      2
`define BIT_MT_SUMMARY      1

// ==========================================================
// Extended option bit positions
`define BIT_EXT_RESERVED    4
`define BIT_GAP_BROADCAST_SEL 3
`define BIT_BUSY_REPORT     2

// ==========================================================
// Identification word busy indication bit
`define BIT_LOGGED_BUSY     9

// ==========================================================
// Write masks and reset values
`define EN_WRITE_MASK       16'hFFC8
`define EXT_WRITE_MASK      16'h001C
`define PEND_RESET          16'h0008
`define EN_RESET            16'h0000
`define EXT_RESET           16'h0000

// ==========================================================
// Serial frame layout
`define SPI_CMD_BITS        5'h08
`define SPI_FRAME_BITS      5'h18
`define SPI_READ_FLAG       7

`endif

// ===== rtl/host_serial_port.v
`timescale 1ns/1ps
`default_nettype none
`include "rt_hw_int_map.vh"

module host_serial_port (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        spi_sck,
    input  wire        spi_cs_n,
    input  wire        spi_mosi,
    output reg         spi_miso,
    output reg  [6:0]  reg_addr,
    output reg         wr_strobe,
    output reg  [15:0] wr_data,
    input  wire [15:0] rd_data
);

    // ======================================================
    // Pin synchronisers
    reg [2:0]  sck_s;
    reg [1:0]  cs_s;
    reg [1:0]  mosi_s;
    reg [4:0]  bit_count;
    reg        is_read;
    reg [15:0] shift_in;
    reg [15:0] shift_out;

    wire sck_rise = sck_s[1] & ~sck_s[2];
    wire sck_fall = ~sck_s[1] & sck_s[2];

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sck_s  <= 3'h0;
            cs_s   <= 2'h3;
            mosi_s <= 2'h0;
        end else begin
            sck_s  <= {sck_s[1:0], spi_sck};
            cs_s   <= {cs_s[0], spi_cs_n};
            mosi_s <= {mosi_s[0], spi_mosi};
        end
    end

    // ======================================================
    // Frame engine: command byte then 16 data bits, MSB first
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_count <= 5'h00;
            is_read   <= 1'b0;
            shift_in  <= 16'h0000;
            shift_out <= 16'h0000;
            reg_addr  <= 7'h00;
            wr_strobe <= 1'b0;
            wr_data   <= 16'h0000;
            spi_miso  <= 1'b0;
        end else begin
            wr_strobe <= 1'b0;
            if (cs_s[1]) begin
                bit_count <= 5'h00;
                spi_miso  <= 1'b0;
            end else if (sck_rise) begin
                shift_in  <= {shift_in[14:0], mosi_s[1]};
                bit_count <= bit_count + 5'h01;
                if (bit_count == `SPI_CMD_BITS - 5'h01) begin
                    is_read   <= shift_in[`SPI_READ_FLAG - 1];
                    reg_addr  <= {shift_in[5:0], mosi_s[1]};
                end
                if (bit_count == `SPI_FRAME_BITS - 5'h01 && !is_read) begin
                    wr_data   <= {shift_in[14:0], mosi_s[1]};
                    wr_strobe <= 1'b1;
                end
            end else if (sck_fall) begin
                if (bit_count == `SPI_CMD_BITS && is_read) begin
                    spi_miso  <= rd_data[15];
                    shift_out <= {rd_data[14:0], 1'b0};
                end else if (bit_count > `SPI_CMD_BITS) begin
                    spi_miso  <= shift_out[15];
                    shift_out <= {shift_out[14:0], 1'b0};
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== rtl/rt_hw_interrupt_block.v
`timescale 1ns/1ps
`default_nettype none
`include "rt_hw_int_map.vh"

module rt_hw_interrupt_block (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire        spi_sck,
    input  wire        spi_cs_n,
    input  wire        spi_mosi,
    output wire        spi_miso,
    input  wire        master_reset_input,
    input  wire [4:0]  term_addr_pins,
    input  wire        term_addr_parity_pin,
    input  wire        mt_tag_increment,
    input  wire [15:0] mt_tag_count,
    input  wire [15:0] mt_tag_match_value,
    input  wire [15:0] rt_pending_bits,
    input  wire [15:0] mt_pending_bits,
    input  wire        rt_event,
    input  wire        rt_event_enabled,
    input  wire [15:0] rt_event_word,
    input  wire        terminal_busy,
    input  wire        gap_error_seen,
    input  wire        broadcast_seen,
    output reg         irq_n,
    output reg         log_write,
    output reg  [15:0] log_word,
    output reg         log_source_rt,
    output reg         gap_broadcast_info_bit
);

    // ======================================================
    // Host port
    wire [6:0]  reg_addr;
    wire        wr_strobe;
    wire [15:0] wr_data;
    reg  [15:0] rd_data;

    host_serial_port u_port (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .spi_sck   (spi_sck),
        .spi_cs_n  (spi_cs_n),
        .spi_mosi  (spi_mosi),
        .spi_miso  (spi_miso),
        .reg_addr  (reg_addr),
        .wr_strobe (wr_strobe),
        .wr_data   (wr_data),
        .rd_data   (rd_data)
    );

    // ======================================================
    // Terminal address capture at master reset rise
    reg [1:0] mrst_sync;
    reg       mrst_prev;
    reg [5:0] addr_s1;
    reg [5:0] addr_s2;
    reg [5:0] captured_addr;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mrst_sync     <= 2'h0;
            mrst_prev     <= 1'b0;
            addr_s1       <= 6'h00;
            addr_s2       <= 6'h00;
            captured_addr <= 6'h00;
        end else begin
            mrst_sync <= {mrst_sync[0], master_reset_input};
            mrst_prev <= mrst_sync[1];
            addr_s1   <= {term_addr_parity_pin, term_addr_pins};
            addr_s2   <= addr_s1;
            if (mrst_sync[1] && !mrst_prev) begin
                captured_addr <= addr_s2;
            end
        end
    end

    // Odd count of ones is the only good pattern
    wire parity_bad = ~^captured_addr;

    // ======================================================
    // Registers
    reg [15:0] int_enable;
    reg [15:0] int_out_enable;
    reg [15:0] ext_config;
    reg        pend_match;
    reg        pend_parity;

    wire wr_enable  = wr_strobe && reg_addr == `ADDR_HW_ENABLE;
    wire wr_out_en  = wr_strobe && reg_addr == `ADDR_HW_OUT_ENABLE;
    wire wr_ext     = wr_strobe && reg_addr == `ADDR_EXT_CONFIG;
    wire wr_pending = wr_strobe && reg_addr == `ADDR_HW_PENDING;

    wire match_event = mt_tag_increment && (mt_tag_count == mt_tag_match_value);
    wire set_match   = match_event && int_enable[`BIT_MON_MATCH];
    wire set_parity  = parity_bad && int_enable[`BIT_ADDR_PARITY];
    wire clr_match   = wr_pending && wr_data[`BIT_MON_MATCH];
    wire clr_parity  = wr_pending && wr_data[`BIT_ADDR_PARITY];

    wire rt_summary = |rt_pending_bits;
    wire mt_summary = |mt_pending_bits;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_enable     <= `EN_RESET;
            int_out_enable <= `EN_RESET;
            ext_config     <= `EXT_RESET;
            pend_match     <= 1'b0;
            pend_parity    <= 1'b1;
        end else begin
            if (wr_enable) begin
                int_enable <= wr_data & `EN_WRITE_MASK;
            end
            if (wr_out_en) begin
                int_out_enable <= wr_data & `EN_WRITE_MASK;
            end
            if (wr_ext) begin
                ext_config <= wr_data & `EXT_WRITE_MASK;
            end
            // Set wins over a clear in the same cycle
            pend_match  <= set_match  | (pend_match  & ~clr_match);
            pend_parity <= set_parity | (pend_parity & ~clr_parity);
        end
    end

    // ======================================================
    // Read mux
    always @* begin
        case (reg_addr)
            `ADDR_HW_PENDING: begin
                rd_data = 16'h0000;
                rd_data[`BIT_MON_MATCH]   = pend_match;
                rd_data[`BIT_ADDR_PARITY] = pend_parity;
                rd_data[`BIT_RT_SUMMARY]  = rt_summary;
                rd_data[`BIT_MT_SUMMARY]  = mt_summary;
            end
            `ADDR_HW_ENABLE: begin
                rd_data = int_enable;
            end
            `ADDR_HW_OUT_ENABLE: begin
                rd_data = int_out_enable;
            end
            `ADDR_EXT_CONFIG: begin
                rd_data = ext_config;
            end
            default: begin
                rd_data = 16'h0000;
            end
        endcase
    end

    // ======================================================
    // Interrupt pin, log writer and info bit
    wire [15:0] new_hw_word = ({15'h0000, set_match & ~pend_match} << `BIT_MON_MATCH) |
                              ({15'h0000, set_parity & ~pend_parity} << `BIT_ADDR_PARITY);
    wire        rt_logged   = rt_event && rt_event_enabled;
    wire        busy_flag   = ext_config[`BIT_BUSY_REPORT] && terminal_busy;
    wire [15:0] busy_mask   = 16'h0001 << `BIT_LOGGED_BUSY;
    wire [15:0] rt_word     = (rt_event_word & ~busy_mask) |
                              (busy_flag ? busy_mask : 16'h0000);

    reg        hw_log_req;
    reg [15:0] hw_log_word;

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_n                  <= 1'b1;
            log_write              <= 1'b0;
            log_word               <= 16'h0000;
            log_source_rt          <= 1'b0;
            hw_log_req             <= 1'b0;
            hw_log_word            <= 16'h0000;
            gap_broadcast_info_bit <= 1'b0;
        end else begin
            irq_n <= ~((pend_match  & int_out_enable[`BIT_MON_MATCH]) |
                       (pend_parity & int_out_enable[`BIT_ADDR_PARITY]));
            gap_broadcast_info_bit <= ext_config[`BIT_GAP_BROADCAST_SEL] ?
                                      broadcast_seen : gap_error_seen;
            log_write <= 1'b0;
            if (rt_logged) begin
                log_write     <= 1'b1;
                log_word      <= rt_word;
                log_source_rt <= 1'b1;
                if (|new_hw_word) begin
                    hw_log_req  <= 1'b1;
                    hw_log_word <= hw_log_word | new_hw_word;
                end
            end else if (hw_log_req || (|new_hw_word)) begin
                log_write     <= 1'b1;
                log_word      <= hw_log_word | new_hw_word;
                log_source_rt <= 1'b0;
                hw_log_req    <= 1'b0;
                hw_log_word   <= 16'h0000;
            end
        end
    end

endmodule

`default_nettype wire

// ===== verif/rt_hw_int_props.sv
`timescale 1ns/1ps
`default_nettype none
module rt_hw_int_props (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic        gap_error_seen,
    input wire logic        broadcast_seen,
    input wire logic        gap_broadcast_info_bit,
    input wire logic        rt_event,
    input wire logic        rt_event_enabled,
    input wire logic [15:0] rt_event_word,
    input wire logic        terminal_busy,
    input wire logic        log_write,
    input wire logic [15:0] log_word,
    input wire logic        log_source_rt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Info bit and log entries
    info_source_a: assert property (
        gap_broadcast_info_bit |-> $past(gap_error_seen) || $past(broadcast_seen))
        else $error("info bit set with no cause");
    rt_logged_a: assert property (
        rt_event && rt_event_enabled |=> log_write && log_source_rt)
        else $error("enabled event not logged");
    rt_cause_a: assert property (
        log_write && log_source_rt |-> $past(rt_event) && $past(rt_event_enabled))
        else $error("log entry without enabled event");
    idle_busy_a: assert property (
        log_write && log_source_rt && !$past(terminal_busy) |-> !log_word[9])
        else $error("busy bit logged while idle");
    word_copy_a: assert property (
        log_write && log_source_rt |-> {log_word[15:10], log_word[8:0]} ==
        {$past(rt_event_word[15:10]), $past(rt_event_word[8:0])})
        else $error("logged word differs from event word");
    hw_entry_a: assert property (
        log_write && !log_source_rt |-> (log_word & 16'hFFB7) == 16'h0000 && log_word != 16'h0000)
        else $error("bad hardware log word");
    busy_alone_a: assert property (
        terminal_busy && !rt_event |=> !(log_write && log_source_rt))
        else $error("busy alone made a log entry");
    masked_event_a: assert property (
        rt_event && !rt_event_enabled |=> !(log_write && log_source_rt))
        else $error("disabled event logged");
endmodule
bind rt_hw_interrupt_block rt_hw_int_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .gap_error_seen(gap_error_seen), .broadcast_seen(broadcast_seen),
    .gap_broadcast_info_bit(gap_broadcast_info_bit), .rt_event(rt_event),
    .rt_event_enabled(rt_event_enabled), .rt_event_word(rt_event_word),
    .terminal_busy(terminal_busy), .log_write(log_write), .log_word(log_word),
    .log_source_rt(log_source_rt));
`default_nettype wire

// ===== verif/host_spi_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_spi_model #(parameter int HALF = 8) (
    input  wire logic core_clk,
    output var  logic spi_sck,
    output var  logic spi_cs_n,
    output var  logic spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end
    // ==========================================
    // One frame: command byte then a 16-bit word, MSB first, mode 0
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        rd = 16'h0000;
        @(posedge core_clk) spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge core_clk) spi_mosi <= sh[i];
            repeat (HALF) @(posedge core_clk);
            spi_sck <= 1'b1;
            if (i < 16) rd = {rd[14:0], spi_miso};
            repeat (HALF) @(posedge core_clk);
            spi_sck <= 1'b0;
        end
        repeat (HALF) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        // Released data line must not keep looking valid
        spi_mosi <= ~spi_mosi;
        repeat (8) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk = 1'b0, sys_rst = 1'b1, mreset = 1'b0, par = 1'b0, inc = 1'b0;
    logic        rt_event = 1'b0, en = 1'b0, busy = 1'b0, gap = 1'b0, bc_seen = 1'b0;
    logic [15:0] ew = 16'h0000;
    logic [4:0]  addr = 5'h00;
    logic [15:0] cnt = 16'h0000, mval = 16'h1234, rtp = 16'h0000, mtp = 16'h0000, v;
    wire         sck, cs_n, mosi, miso, irq_n, log_write, log_src, info;
    wire  [15:0] log_word;
    int          mismatches = 0, comparisons = 0, cycles = 0;

    always #5 core_clk = ~core_clk;

    host_spi_model host (.core_clk(core_clk), .spi_sck(sck), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .spi_miso(miso));
    rt_hw_interrupt_block uut (.core_clk(core_clk), .sys_rst(sys_rst), .spi_sck(sck),
        .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .master_reset_input(mreset),
        .term_addr_pins(addr), .term_addr_parity_pin(par), .mt_tag_increment(inc),
        .mt_tag_count(cnt), .mt_tag_match_value(mval), .rt_pending_bits(rtp),
        .mt_pending_bits(mtp), .rt_event(rt_event), .rt_event_enabled(en),
        .rt_event_word(ew), .terminal_busy(busy), .gap_error_seen(gap),
        .broadcast_seen(bc_seen), .irq_n(irq_n), .log_write(log_write), .log_word(log_word),
        .log_source_rt(log_src), .gap_broadcast_info_bit(info));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer({1'b0, a}, d, v);
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        host.xfer({1'b1, a}, 16'h0000, v);
        check("register", v, exp);
    endtask
    task automatic latch(input logic [4:0] a, input logic p);
        addr <= a;
        par <= p;
        repeat (4) @(posedge core_clk);
        mreset <= 1'b1;
        repeat (6) @(posedge core_clk);
        mreset <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask
    task automatic rt_try(input logic b, input logic e, input logic [15:0] w,
                          input logic [15:0] exp);
        busy <= b;
        en <= e;
        ew <= w;
        rt_event <= 1'b1;
        @(posedge core_clk) rt_event <= 1'b0;
        #1;
        check("log_write", log_write, e);
        if (e) begin
            check("log_word", log_word, exp);
            check("log_source_rt", log_src, 1'b1);
        end
        @(posedge core_clk);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        // ==========================================
        // Reset values and write masks
        rd(7'h4D, 16'h0000);
        rd(7'h06, 16'h0008);
        rd(7'h0F, 16'h0000);
        wr(7'h0F, 16'hFFFF);
        rd(7'h0F, 16'hFFC8);
        wr(7'h13, 16'hFFFF);
        rd(7'h13, 16'hFFC8);
        check("irq_n", irq_n, 1'b0);
        $display("test done: registers");
        // ==========================================
        // Address parity latched at master reset
        latch(5'h01, 1'b0);
        wr(7'h06, 16'h0008);
        rd(7'h06, 16'h0000);
        check("irq_n", irq_n, 1'b1);
        latch(5'h03, 1'b0);
        rd(7'h06, 16'h0008);
        latch(5'h03, 1'b1);
        wr(7'h06, 16'h0008);
        rd(7'h06, 16'h0000);
        $display("test done: parity");
        // ==========================================
        // Summary bits and tag match
        rtp <= 16'h0200;
        rd(7'h06, 16'h0004);
        mtp <= 16'h0001;
        rd(7'h06, 16'h0006);
        rtp <= 16'h0000;
        mtp <= 16'h0000;
        rd(7'h06, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            cnt <= 16'h1233 + 16'(k);
            inc <= 1'b1;
            @(posedge core_clk) inc <= 1'b0;
            rd(7'h06, k ? 16'h0040 : 16'h0000);
        end
        check("irq_n", irq_n, 1'b0);
        wr(7'h06, 16'h0040);
        rd(7'h06, 16'h0000);
        $display("test done: pending");
        // ==========================================
        // Option register, reserved bit 4 left clear
        wr(7'h4D, 16'hFFEF);
        rd(7'h4D, 16'h000C);
        gap <= 1'b1;
        wr(7'h4D, 16'h0008);
        check("info", info, 1'b0);
        wr(7'h4D, 16'h0000);
        check("info", info, 1'b1);
        wr(7'h4D, 16'h0004);
        rt_try(1'b1, 1'b1, 16'h0021, 16'h0221);
        rt_try(1'b0, 1'b1, 16'h0221, 16'h0021);
        rt_try(1'b1, 1'b0, 16'h0021, 16'h0000);
        wr(7'h4D, 16'h0000);
        rt_try(1'b1, 1'b1, 16'h0221, 16'h0021);
        rd(7'h06, 16'h0000);
        $display("test done: options");
        finish_test();
    end
endmodule
`default_nettype wire
